/* pahap_pkg.sv */
// Constants shared by the palette host access port and its storage.
package pahap_pkg;
  localparam logic [2:0] RS_PTR_PAL_WR = 3'h0;
  localparam logic [2:0] RS_PAL_DATA   = 3'h1;
  localparam logic [2:0] RS_MASK       = 3'h2;
  localparam logic [2:0] RS_PTR_PAL_RD = 3'h3;
  localparam logic [2:0] RS_PTR_OVL_WR = 3'h4;
  localparam logic [2:0] RS_OVL_DATA   = 3'h5;
  localparam logic [2:0] RS_CMD        = 3'h6;
  localparam logic [2:0] RS_PTR_OVL_RD = 3'h7;
  localparam logic [1:0] PH_RED        = 2'h0;
  localparam logic [1:0] PH_GREEN      = 2'h1;
  localparam logic [1:0] PH_BLUE       = 2'h2;
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'hff;
  localparam int         CMD_MODE_HI   = 7;
  localparam int         CMD_MODE_LO   = 6;
  localparam int         CMD_WIDE      = 4;
  localparam int         PAL_DEPTH     = 256;
  localparam int         OVL_COUNT     = 15;
  typedef enum logic [1:0] {
    PAHAP_F_IDLE = 2'h0,
    PAHAP_F_WAIT = 2'h1,
    PAHAP_F_LOAD = 2'h3
  } pahap_fetch_t;
endpackage

/* pahap_ram.sv */
// One palette channel: one write port and two registered read ports.
`timescale 1ns/100ps
module pahap_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic             i_mclk,
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic [AW-1:0]    i_pix_addr,
  output logic      [WIDTH-1:0] o_pix_data,
  input  wire logic [AW-1:0]    i_host_addr,
  output logic      [WIDTH-1:0] o_host_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Storage has no reset; both read ports deliver one cycle after the address.
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_pix_data  <= mem[i_pix_addr];
    o_host_data <= mem[i_host_addr];
  end
endmodule

/* pahap_top.sv */
// Host access port, hidden phase counter, color storage and pixel color path.
`timescale 1ns/100ps
module pahap_top
  import pahap_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_wr_n,
  input  wire logic       i_rd_n,
  input  wire logic [2:0] i_rs,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  input  wire logic [7:0] i_pix_red,
  input  wire logic [7:0] i_pix_green,
  input  wire logic [7:0] i_pix_blue,
  input  wire logic [3:0] i_ovl_sel,
  input  wire logic [1:0] i_mode_sel,
  output logic      [7:0] o_dac_red,
  output logic      [7:0] o_dac_green,
  output logic      [7:0] o_dac_blue,
  output logic      [3:0] o_cmd_low
);
  logic [7:0]   ptr, next_ptr;
  logic [1:0]   phase, next_phase;
  logic [7:0]   hold_r, hold_g, hold_b, next_hold_r, next_hold_g, next_hold_b;
  logic [7:0]   mask, next_mask;
  logic [7:0]   cmd;
  logic [2:0]   rs_q, next_rs_q;
  logic [7:0]   data_q, next_data_q;
  logic         wr_low_q, rd_low_q;
  logic         fetch_ovl, next_fetch_ovl;
  logic [7:0]   next_o_data;
  pahap_fetch_t fstate, next_fstate;
  logic [23:0]  ovl [1:OVL_COUNT];
  logic [23:0]  next_ovl [1:OVL_COUNT];
  logic         pal_we;
  logic [23:0]  pal_wdata, pal_host, pal_pix;
  logic [7:0]   pix_addr_r, pix_addr_g, pix_addr_b;
  logic         wr_end, rd_start, rd_end, wide, is_data;
  logic [7:0]   cin, hsel;
  logic [23:0]  ovl_word, wr_word;

  // Strobe edges; writes commit at the rising edge with the last sampled data.
  assign wr_end   = wr_low_q && i_wr_n;
  assign rd_start = !i_rd_n && !rd_low_q;
  assign rd_end   = rd_low_q && i_rd_n;
  assign wide     = cmd[CMD_WIDE];
  assign is_data  = (rs_q == RS_PAL_DATA) || (rs_q == RS_OVL_DATA);
  // Narrow data sits at the top of the byte so the converter LSBs read zero.
  assign cin      = wide ? data_q : {data_q[5:0], 2'h0};
  assign wr_word  = {hold_r, hold_g, cin};
  assign ovl_word = (ptr[3:0] == 4'h0) ? 24'h000000 : ovl[ptr[3:0]];
  assign hsel     = (phase == PH_RED) ? hold_r : (phase == PH_GREEN) ? hold_g : hold_b;

  // Host-side next state: decode, phase counter, pointer and holding registers.
  always_comb begin
    next_ptr       = ptr;
    next_phase     = phase;
    next_hold_r    = hold_r;
    next_hold_g    = hold_g;
    next_hold_b    = hold_b;
    next_mask      = mask;
    next_fetch_ovl = fetch_ovl;
    next_fstate    = fstate;
    next_ovl       = ovl;
    next_rs_q      = (!i_wr_n || !i_rd_n) ? i_rs : rs_q;
    next_data_q    = !i_wr_n ? i_data : data_q;
    next_o_data    = o_data;
    pal_we         = 1'b0;
    pal_wdata      = wr_word;
    if (rd_start) begin
      case (i_rs)
        RS_PTR_PAL_WR, RS_PTR_PAL_RD, RS_PTR_OVL_WR, RS_PTR_OVL_RD: next_o_data = ptr;
        RS_PAL_DATA, RS_OVL_DATA: next_o_data = wide ? hsel : {2'h0, hsel[7:2]};
        RS_MASK: next_o_data = mask;
        default: next_o_data = cmd;
      endcase
    end
    if (wr_end) begin
      case (rs_q)
        RS_PTR_PAL_WR, RS_PTR_OVL_WR: begin
          next_ptr   = data_q;
          next_phase = PH_RED;
        end
        RS_PTR_PAL_RD, RS_PTR_OVL_RD: begin
          next_ptr       = data_q;
          next_phase     = PH_RED;
          next_fetch_ovl = rs_q[2];
          next_fstate    = PAHAP_F_WAIT;
        end
        RS_PAL_DATA, RS_OVL_DATA: begin
          case (phase)
            PH_RED: begin
              next_hold_r = cin;
              next_phase  = PH_GREEN;
            end
            PH_GREEN: begin
              next_hold_g = cin;
              next_phase  = PH_BLUE;
            end
            default: begin
              next_hold_b = cin;
              next_phase  = PH_RED;
              next_ptr    = ptr + 8'h01;
              if (!rs_q[2]) begin
                pal_we = 1'b1;
              end else if (ptr[3:0] != 4'h0) begin
                next_ovl[ptr[3:0]] = wr_word;
              end
            end
          endcase
        end
        RS_MASK: next_mask = data_q;
        default: next_mask = mask;
      endcase
    end
    if (rd_end && is_data) begin
      next_phase = (phase == PH_RED) ? PH_GREEN : (phase == PH_GREEN) ? PH_BLUE : PH_RED;
      if (phase == PH_BLUE) begin
        next_fetch_ovl = rs_q[2];
        next_fstate    = PAHAP_F_WAIT;
      end
    end
    // The fetch runs in the gap after a strobe, while the host is idle.
    case (fstate)
      PAHAP_F_IDLE: next_fstate = next_fstate;
      PAHAP_F_WAIT: next_fstate = PAHAP_F_LOAD;
      PAHAP_F_LOAD: begin
        next_fstate = PAHAP_F_IDLE;
        next_ptr    = ptr + 8'h01;
        if (fetch_ovl) begin
          {next_hold_r, next_hold_g, next_hold_b} = ovl_word;
        end else begin
          {next_hold_r, next_hold_g, next_hold_b} = pal_host;
        end
      end
      default: next_fstate = PAHAP_F_IDLE;
    endcase
  end

  // Host-side registers.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr       <= PTR_RESET;
      phase     <= PH_RED;
      hold_r    <= 8'h00;
      hold_g    <= 8'h00;
      hold_b    <= 8'h00;
      mask      <= MASK_RESET;
      rs_q      <= 3'h0;
      data_q    <= 8'h00;
      wr_low_q  <= 1'b0;
      rd_low_q  <= 1'b0;
      fetch_ovl <= 1'b0;
      fstate    <= PAHAP_F_IDLE;
      o_data    <= 8'h00;
      o_data_oe <= 1'b0;
      for (int i = 1; i <= OVL_COUNT; i++) begin
        ovl[i] <= 24'h000000;
      end
    end else begin
      ptr       <= next_ptr;
      phase     <= next_phase;
      hold_r    <= next_hold_r;
      hold_g    <= next_hold_g;
      hold_b    <= next_hold_b;
      mask      <= next_mask;
      rs_q      <= next_rs_q;
      data_q    <= next_data_q;
      wr_low_q  <= !i_wr_n;
      rd_low_q  <= !i_rd_n;
      fetch_ovl <= next_fetch_ovl;
      fstate    <= next_fstate;
      o_data    <= next_o_data;
      o_data_oe <= !i_rd_n;
      ovl       <= next_ovl;
    end
  end

  // The command register deliberately has no reset; it holds garbage until written.
  always_ff @(posedge i_mclk) begin
    if (wr_end && rs_q == RS_CMD) begin
      cmd <= data_q;
    end
  end
  assign o_cmd_low = cmd[3:0];

  // Pixel stage 1: inputs and mode select move together through the pipeline.
  logic [7:0] p1_r, p1_g, p1_b, p2_r, p2_g, p2_b;
  logic [3:0] p1_ovl, p2_ovl;
  logic [1:0] p1_sel, p2_sel;
  logic [7:0] pseudo_src, next_dac_r, next_dac_g, next_dac_b, tc_src;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {p1_r, p1_g, p1_b, p2_r, p2_g, p2_b} <= 48'h000000000000;
      {p1_ovl, p2_ovl, p1_sel, p2_sel}     <= 12'h000;
      {o_dac_red, o_dac_green, o_dac_blue} <= 24'h000000;
    end else begin
      {p1_r, p1_g, p1_b, p1_ovl, p1_sel} <= {i_pix_red, i_pix_green, i_pix_blue, i_ovl_sel, i_mode_sel};
      {p2_r, p2_g, p2_b, p2_ovl, p2_sel} <= {p1_r, p1_g, p1_b, p1_ovl, p1_sel};
      {o_dac_red, o_dac_green, o_dac_blue} <= {next_dac_r, next_dac_g, next_dac_b};
    end
  end

  // Palette addresses: per-channel in true color, one shared index in pseudo color.
  always_comb begin
    case (cmd[CMD_MODE_HI:CMD_MODE_LO])
      2'h0:    pseudo_src = p1_r;
      2'h1:    pseudo_src = p1_g;
      default: pseudo_src = p1_b;
    endcase
    if (p1_sel == 2'h2) begin
      pix_addr_r = pseudo_src & mask;
      pix_addr_g = pseudo_src & mask;
      pix_addr_b = pseudo_src & mask;
    end else begin
      pix_addr_r = p1_r & mask;
      pix_addr_g = p1_g & mask;
      pix_addr_b = p1_b & mask;
    end
  end

  // Output select; overlay wins, then the mode pair picks the source.
  always_comb begin
    case (cmd[CMD_MODE_HI:CMD_MODE_LO])
      2'h0:    tc_src = p2_r;
      2'h1:    tc_src = p2_g;
      default: tc_src = p2_b;
    endcase
    {next_dac_r, next_dac_g, next_dac_b} = pal_pix;
    if (p2_ovl != 4'h0) begin
      {next_dac_r, next_dac_g, next_dac_b} = ovl[p2_ovl];
    end else if (cmd[CMD_MODE_HI:CMD_MODE_LO] == 2'h3 && p2_sel != 2'h3) begin
      {next_dac_r, next_dac_g, next_dac_b} = 24'h000000;
    end else if (p2_sel == 2'h1) begin
      {next_dac_r, next_dac_g, next_dac_b} = {p2_r, p2_g, p2_b};
    end else if (p2_sel == 2'h3 && cmd[CMD_MODE_HI:CMD_MODE_LO] == 2'h3) begin
      next_dac_r = {p2_r[6:2], 3'h0};
      next_dac_g = {p2_r[1:0], p2_g[7:5], 3'h0};
      next_dac_b = {p2_g[4:0], 3'h0};
    end else if (p2_sel == 2'h3) begin
      next_dac_r = {tc_src[7:5], 5'h00};
      next_dac_g = {tc_src[4:2], 5'h00};
      next_dac_b = {tc_src[1:0], 6'h00};
    end
  end

  // Three channel RAMs; the host read port always looks at the pointer.
  pahap_ram #(.WIDTH(8), .DEPTH(PAL_DEPTH), .AW(8)) u_ram_r (
    .i_mclk(i_mclk), .i_we(pal_we), .i_waddr(ptr), .i_wdata(pal_wdata[23:16]),
    .i_pix_addr(pix_addr_r), .o_pix_data(pal_pix[23:16]), .i_host_addr(ptr), .o_host_data(pal_host[23:16]));
  pahap_ram #(.WIDTH(8), .DEPTH(PAL_DEPTH), .AW(8)) u_ram_g (
    .i_mclk(i_mclk), .i_we(pal_we), .i_waddr(ptr), .i_wdata(pal_wdata[15:8]),
    .i_pix_addr(pix_addr_g), .o_pix_data(pal_pix[15:8]), .i_host_addr(ptr), .o_host_data(pal_host[15:8]));
  pahap_ram #(.WIDTH(8), .DEPTH(PAL_DEPTH), .AW(8)) u_ram_b (
    .i_mclk(i_mclk), .i_we(pal_we), .i_waddr(ptr), .i_wdata(pal_wdata[7:0]),
    .i_pix_addr(pix_addr_b), .o_pix_data(pal_pix[7:0]), .i_host_addr(ptr), .o_host_data(pal_host[7:0]));

  // Checks on the host port behaviour.
  property p_phase_legal;
    @(posedge i_mclk) disable iff (!i_rst_n) phase != 2'h3;
  endproperty
  a_phase_legal: assert property (p_phase_legal) else $error("phase reached illegal code");
  property p_ptr_wr_clears;
    @(posedge i_mclk) disable iff (!i_rst_n)
      wr_end && (rs_q == RS_PTR_PAL_WR || rs_q == RS_PTR_OVL_WR) |=> phase == PH_RED && ptr == $past(data_q);
  endproperty
  a_ptr_wr_clears: assert property (p_ptr_wr_clears) else $error("pointer write did not load or clear phase");
  property p_ptr_rd_still;
    @(posedge i_mclk) disable iff (!i_rst_n)
      rd_end && rs_q[1:0] != 2'h1 && rs_q != RS_MASK && rs_q != RS_CMD && fstate == PAHAP_F_IDLE && i_wr_n
      |=> $stable(ptr) && $stable(phase);
  endproperty
  a_ptr_rd_still: assert property (p_ptr_rd_still) else $error("pointer read changed state");
  property p_blue_wr_inc;
    @(posedge i_mclk) disable iff (!i_rst_n)
      wr_end && is_data && phase == PH_BLUE |=> ptr == 8'($past(ptr) + 8'h01) && phase == PH_RED;
  endproperty
  a_blue_wr_inc: assert property (p_blue_wr_inc) else $error("blue write did not advance pointer");
  property p_fetch_done;
    @(posedge i_mclk) disable iff (!i_rst_n)
      fstate == PAHAP_F_WAIT |=> fstate == PAHAP_F_LOAD ##1 fstate == PAHAP_F_IDLE;
  endproperty
  a_fetch_done: assert property (p_fetch_done) else $error("fetch did not finish in two cycles");
  property p_fetch_inc;
    @(posedge i_mclk) disable iff (!i_rst_n)
      fstate == PAHAP_F_LOAD && !wr_end |=> ptr == 8'($past(ptr) + 8'h01);
  endproperty
  a_fetch_inc: assert property (p_fetch_inc) else $error("fetch did not advance pointer");
  property p_narrow_read;
    @(posedge i_mclk) disable iff (!i_rst_n)
      rd_start && !wide && (i_rs == RS_PAL_DATA || i_rs == RS_OVL_DATA) |=> o_data[7:6] == 2'h0;
  endproperty
  a_narrow_read: assert property (p_narrow_read) else $error("narrow read drove upper bits");
  property p_oe_follows;
    @(posedge i_mclk) disable iff (!i_rst_n) !i_rd_n ##1 !i_rd_n |-> o_data_oe;
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("bus not driven during read");
  property p_mask_write;
    @(posedge i_mclk) disable iff (!i_rst_n) wr_end && rs_q == RS_MASK |=> mask == $past(data_q);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");
endmodule

/* pahap_host.sv */
// Behavioural host processor model that drives the asynchronous parallel register bus.
`timescale 1ns/100ps
module pahap_host (
  input  wire logic       i_mclk,
  output logic            o_wr_n,
  output logic            o_rd_n,
  output logic [2:0]      o_rs,
  output logic [7:0]      o_data
);
  // Idle bus: both strobes high, data lines hold the pattern 5a until the first access.
  initial begin
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_rs = 3'h0;
    o_data = 8'h5a;
  end

  // One access: the strobe stays low for two samples and rises after them.
  // Select and data stay put until the edge that samples the rising strobe.
  // Four high samples follow, so the two-cycle fetch after a read-mode load or blue read ends first.
  task automatic access(input logic wr, input logic [2:0] rs, input logic [7:0] d);
    @(posedge i_mclk);
    o_rs <= rs;
    o_data <= d;
    if (wr) begin
      o_wr_n <= 1'b0;
    end else begin
      o_rd_n <= 1'b0;
    end
    repeat (2) @(posedge i_mclk);
    o_wr_n <= 1'b1;
    o_rd_n <= 1'b1;
    @(posedge i_mclk);
    o_data <= ~d;  // Released lines show the inverse so a stale value never passes.
    repeat (3) @(posedge i_mclk);
  endtask
endmodule

/* testbench.sv */
// Self-checking bench for the palette host access port driven by the host bus model.
`timescale 1ns/100ps
module testbench
  import pahap_pkg::*;
;
  logic        i_mclk;
  logic        i_rst_n;
  logic        wr_n;
  logic        rd_n;
  logic [2:0]  rs;
  logic [7:0]  hdata;
  logic [7:0]  o_data;
  logic        o_data_oe;
  logic [7:0]  i_pix_red;
  logic [7:0]  i_pix_green;
  logic [7:0]  i_pix_blue;
  logic [3:0]  i_ovl_sel;
  logic [1:0]  i_mode_sel;
  logic [7:0]  o_dac_red;
  logic [7:0]  o_dac_green;
  logic [7:0]  o_dac_blue;
  logic [3:0]  o_cmd_low;
  logic [31:0] rnd_state = 32'ha8100919;
  logic [23:0] pal_m [256];
  logic [23:0] ovl_m [16];
  logic [7:0]  exp_q [$];
  logic        oe_d;
  logic        pix_hold;
  logic [23:0] hold_px;
  int          bad_count;
  int          total_checks;
  int          cyc;

  pahap_host u_host (.i_mclk(i_mclk), .o_wr_n(wr_n), .o_rd_n(rd_n), .o_rs(rs), .o_data(hdata));

  pahap_top u_pahap_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wr_n(wr_n), .i_rd_n(rd_n), .i_rs(rs),
    .i_data(hdata), .o_data(o_data), .o_data_oe(o_data_oe), .i_pix_red(i_pix_red),
    .i_pix_green(i_pix_green), .i_pix_blue(i_pix_blue), .i_ovl_sel(i_ovl_sel), .i_mode_sel(i_mode_sel),
    .o_dac_red(o_dac_red), .o_dac_green(o_dac_green), .o_dac_blue(o_dac_blue), .o_cmd_low(o_cmd_low));

  // Shift register source of random values.
  function automatic logic [31:0] next_rnd();
    rnd_state = {rnd_state[30:0], 1'b0} ^ (rnd_state[31] ? 32'h04c11db7 : 32'h0);
    return rnd_state;
  endfunction

  // Free-running clock at 200 MHz.
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  // Pixel inputs carry random traffic except while a pixel check holds them.
  always @(posedge i_mclk) begin
    if (pix_hold) begin
      {i_pix_red, i_pix_green, i_pix_blue} <= hold_px;
    end else begin
      {i_pix_red, i_pix_green, i_pix_blue} <= 24'(next_rnd());
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] want);
    total_checks++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected %0t byte %h, expected %h", $time, got, want);
    end
  endtask

  task automatic chk_pix(input logic [23:0] got, input logic [23:0] want);
    total_checks++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected %0t converter word %h, expected %h", $time, got, want);
    end
  endtask

  // A read answer appears when the data enable rises; it meets the oldest noted byte.
  always @(negedge i_mclk) begin
    if (o_data_oe === 1'b1 && oe_d !== 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("unexpected %0t read answer with nothing expected", $time);
      end else begin
        chk_byte(o_data, exp_q.pop_front());
      end
    end
    oe_d = o_data_oe;
  end

  task automatic conclude();
    // A read whose answer never showed up would otherwise leave its note behind unnoticed.
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("unexpected %0t %0d read answers never appeared", $time, exp_q.size());
    end
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall forever; the whole run needs about 530 cycles.
  initial begin
    cyc = 0;
    forever begin
      @(posedge i_mclk);
      cyc++;
      if (cyc == 20000) begin
        bad_count++;
        conclude();
      end
    end
  end

  task automatic wr(input logic [2:0] r, input logic [7:0] d);
    u_host.access(1'b1, r, d);
  endtask

  task automatic rd(input logic [2:0] r, input logic [7:0] want);
    exp_q.push_back(want);
    u_host.access(1'b0, r, 8'h00);
  endtask

  task automatic wr_rgb(input logic [2:0] r, input logic [23:0] v);
    wr(r, v[23:16]);
    wr(r, v[15:8]);
    wr(r, v[7:0]);
  endtask

  // Reads n entries from idx; the pointer then sits one past the prefetched entry.
  task automatic rd_rgb(input logic ovl, input logic [7:0] idx, input int n, input logic narrow);
    logic [23:0] v;
    wr(ovl ? RS_PTR_OVL_RD : RS_PTR_PAL_RD, idx);
    for (int k = 0; k < n; k++) begin
      v = ovl ? ovl_m[4'(idx + 8'(k))] : pal_m[8'(idx + 8'(k))];
      for (int c = 2; c >= 0; c--) begin
        rd(ovl ? RS_OVL_DATA : RS_PAL_DATA, v[c*8 +: 8] & (narrow ? 8'h3f : 8'hff));
      end
    end
    rd(RS_PTR_PAL_WR, idx + 8'(n + 1));
  endtask

  // Holds mode, overlay and pixels long enough for the three-stage pixel pipeline.
  task automatic pix_chk(input logic [1:0] m, input logic [3:0] ov, input logic [23:0] px, input logic [23:0] want);
    @(posedge i_mclk);
    i_mode_sel <= m;
    i_ovl_sel <= ov;
    hold_px <= px;
    pix_hold <= 1'b1;
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk);
    chk_pix({o_dac_red, o_dac_green, o_dac_blue}, want);
    pix_hold <= 1'b0;
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // Main sequence.
  initial begin
    logic [23:0] v;
    i_rst_n = 1'b0;
    i_mode_sel = 2'h0;
    i_ovl_sel = 4'h0;
    {i_pix_red, i_pix_green, i_pix_blue} = 24'h000000;
    pix_hold = 1'b0;
    hold_px = 24'h000000;
    bad_count = 0;
    total_checks = 0;
    oe_d = 1'b0;
    for (int i = 0; i < 16; i++) ovl_m[i] = 24'h000000;
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    wr(RS_CMD, 8'h1a);
    rd(RS_CMD, 8'h1a);
    chk_byte({4'h0, o_cmd_low}, 8'h0a);
    wr(RS_MASK, 8'hff);
    rd(RS_MASK, 8'hff);
    done("command");
    wr(RS_PTR_PAL_WR, 8'hfe);
    for (int k = 0; k < 2; k++) begin
      v = 24'(next_rnd());
      pal_m[8'hfe + 8'(k)] = v;
      wr_rgb(RS_PAL_DATA, v);
    end
    rd(RS_PTR_PAL_WR, 8'h00);
    rd_rgb(1'b0, 8'hfe, 2, 1'b0);
    done("palette wrap");
    wr(RS_PTR_PAL_WR, 8'h05);
    wr(RS_PAL_DATA, 8'haa);
    wr(RS_PAL_DATA, 8'hbb);
    wr(RS_PTR_PAL_WR, 8'h05);
    wr(RS_PAL_DATA, 8'h3c);
    rd(RS_PTR_PAL_WR, 8'h05);
    wr(RS_PAL_DATA, 8'hc3);
    wr(RS_PAL_DATA, 8'h5a);
    pal_m[5] = 24'h3cc35a;
    rd(RS_PTR_PAL_RD, 8'h06);
    rd_rgb(1'b0, 8'h05, 1, 1'b0);
    done("phase");
    pix_chk(2'h0, 4'h0, {3{8'hfe}}, pal_m[8'hfe]);
    wr(RS_MASK, 8'h0f);
    pix_chk(2'h0, 4'h0, {3{8'hf5}}, pal_m[5]);
    wr(RS_MASK, 8'hff);
    v = 24'(next_rnd());
    pix_chk(2'h1, 4'h0, v, v);
    done("pixel");
    wr(RS_PTR_OVL_WR, 8'hf3);
    v = 24'(next_rnd());
    ovl_m[3] = v;
    wr_rgb(RS_OVL_DATA, v);
    wr(RS_PTR_OVL_WR, 8'h00);
    wr_rgb(RS_OVL_DATA, 24'hffffff);
    rd_rgb(1'b1, 8'h00, 1, 1'b0);
    rd_rgb(1'b1, 8'hf3, 1, 1'b0);
    pix_chk(2'h0, 4'h3, 24'h000000, ovl_m[3]);
    done("overlay");
    wr(RS_CMD, 8'h05);
    chk_byte({4'h0, o_cmd_low}, 8'h05);
    wr(RS_PTR_PAL_WR, 8'h20);
    pal_m[8'h20] = 24'hffc57a;
    wr_rgb(RS_PAL_DATA, 24'hffc57a);
    rd_rgb(1'b0, 8'h20, 1, 1'b1);
    pix_chk(2'h0, 4'h0, {3{8'h20}}, 24'hfc14e8);
    done("narrow");
    // Pseudo color takes the red index for all three channels; green and blue entries 00 were never written.
    pix_chk(2'h2, 4'h0, {8'h20, 8'h00, 8'h00}, 24'hfc14e8);
    pix_chk(2'h3, 4'h0, {8'hb6, 8'h00, 8'h00}, 24'ha0a080);
    wr(RS_CMD, 8'hc0);
    pix_chk(2'h3, 4'h0, {8'h5a, 8'h3c, 8'h00}, 24'hb088e0);
    pix_chk(2'h0, 4'h0, {3{8'h20}}, 24'h000000);
    done("modes");
    conclude();
  end
endmodule
